// ---- rtl/imc_pkg.sv ----
// Constants, field layout and types of the two-wire master configuration
// block. Assumes a 20 MHz system clock and APB byte addressing.
package imc_pkg;
  localparam int          ADDR_W        = 20;
  localparam logic [19:0] OFF_ID        = 20'h1d100;
  localparam logic [19:0] OFF_RST       = 20'h1d104;
  localparam logic [19:0] OFF_CFG       = 20'h1d108;
  // Revision value is arbitrary.
  localparam logic [3:0]  REV_VALUE     = 4'h3;
  localparam int          REV_LSB       = 0;
  localparam int          SRST_BIT      = 31;
  localparam int          ORDER_BIT     = 23;
  localparam int          PAW_LSB       = 16;
  localparam int          DEV_LSB       = 0;
  localparam logic [1:0]  PAW_NONE      = 2'h0;
  localparam logic [1:0]  PAW_LOW       = 2'h1;
  localparam logic [1:0]  PAW_BOTH      = 2'h2;
  localparam logic        ORDER_RST     = 1'h0;
  localparam logic [1:0]  PAW_RST       = 2'h0;
  localparam logic [6:0]  DEV_RST       = 7'h00;
  localparam logic [2:0]  MAX_BYTES     = 3'h4;
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          QTR_TIME_NS   = 2500;
  localparam int          QTR_CYC       = QTR_TIME_NS / CLK_PERIOD_NS;
  localparam int          IDLE_TIME_NS  = 5000;
  localparam int          IDLE_CYC      =
    (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {CMD_START, CMD_BYTE, CMD_STOP} imc_cmd_t;
  typedef enum logic [3:0] {
    SQ_IDLE, SQ_START, SQ_DEVW, SQ_OFFH, SQ_OFFL,
    SQ_RSTART, SQ_DEVR, SQ_DATA, SQ_STOP
  } imc_seq_t;
endpackage

// ---- rtl/imc_bit_engine.sv ----
// Bit-level two-wire engine: start, stop and nine-bit byte slots.
// Assumes open-drain pins resolved outside; an enable high pulls low.
`timescale 1ns/1ps
module imc_bit_engine (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             hold_in,
  input  wire logic             cmd_valid_in,
  input  wire imc_pkg::imc_cmd_t cmd_in,
  input  wire logic [8:0]       tx_in,
  output logic                  ready_out,
  output logic                  done_out,
  output logic [8:0]            rx_out,
  input  wire logic             scl_in,
  output logic                  scl_out,
  output logic                  scl_oe_out,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe_out
);
  typedef enum logic [1:0] {E_IDLE, E_START, E_BYTE, E_STOP} imc_eng_t;

  imc_eng_t    state_r;
  logic [1:0]  phase_r;
  logic [3:0]  bitn_r;
  logic [8:0]  sh_r;
  logic [8:0]  rx_r;
  logic        scl_low_r;
  logic        sda_low_r;
  logic        done_r;
  logic [7:0]  qcnt_r;
  logic        tick;

  assign tick       = (qcnt_r == 8'(imc_pkg::QTR_CYC - 1));
  assign ready_out  = (state_r == E_IDLE) && !hold_in;
  assign done_out   = done_r;
  assign rx_out     = rx_r;
  assign scl_out    = 1'h0;
  assign sda_out    = 1'h0;
  assign scl_oe_out = scl_low_r;
  assign sda_oe_out = sda_low_r;

  // The quarter-bit divider restarts with each command so timing is even.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      qcnt_r <= 8'h00;
    end else if (hold_in || state_r == E_IDLE || tick) begin
      qcnt_r <= 8'h00;
    end else begin
      qcnt_r <= qcnt_r + 8'h01;
    end
  end

  // Clock stretching by a slave is not honoured; scl_in is not sampled.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r   <= E_IDLE;
      phase_r   <= 2'h0;
      bitn_r    <= 4'h0;
      sh_r      <= 9'h1ff;
      rx_r      <= 9'h000;
      scl_low_r <= 1'h0;
      sda_low_r <= 1'h0;
      done_r    <= 1'h0;
    end else if (hold_in) begin
      state_r   <= E_IDLE;
      phase_r   <= 2'h0;
      bitn_r    <= 4'h0;
      rx_r      <= 9'h000;
      scl_low_r <= 1'h0;
      sda_low_r <= 1'h0;
      done_r    <= 1'h0;
    end else begin
      done_r <= 1'h0;
      case (state_r)
        E_IDLE: begin
          if (cmd_valid_in) begin
            phase_r <= 2'h0;
            bitn_r  <= 4'h0;
            sh_r    <= tx_in;
            case (cmd_in)
              imc_pkg::CMD_START: state_r <= E_START;
              imc_pkg::CMD_BYTE:  state_r <= E_BYTE;
              default:            state_r <= E_STOP;
            endcase
          end
        end
        E_START: begin
          if (tick) begin
            phase_r <= phase_r + 2'h1;
            case (phase_r)
              2'h0: sda_low_r <= 1'h0;
              2'h1: scl_low_r <= 1'h0;
              2'h2: sda_low_r <= 1'h1;
              default: begin
                scl_low_r <= 1'h1;
                state_r   <= E_IDLE;
                done_r    <= 1'h1;
              end
            endcase
          end
        end
        E_BYTE: begin
          if (tick) begin
            phase_r <= phase_r + 2'h1;
            case (phase_r)
              2'h0: sda_low_r <= !sh_r[8];
              2'h1: scl_low_r <= 1'h0;
              2'h2: rx_r      <= {rx_r[7:0], sda_in};
              default: begin
                scl_low_r <= 1'h1;
                sh_r      <= {sh_r[7:0], 1'h1};
                bitn_r    <= bitn_r + 4'h1;
                if (bitn_r == 4'h8) begin
                  state_r <= E_IDLE;
                  done_r  <= 1'h1;
                end
              end
            endcase
          end
        end
        default: begin
          if (tick) begin
            phase_r <= phase_r + 2'h1;
            case (phase_r)
              2'h0: sda_low_r <= 1'h1;
              2'h1: scl_low_r <= 1'h0;
              2'h2: sda_low_r <= 1'h0;
              default: begin
                state_r <= E_IDLE;
                done_r  <= 1'h1;
              end
            endcase
          end
        end
      endcase
    end
  end
endmodule

// ---- rtl/imc_top.sv ----
// APB register file, soft reset and master transfer sequencer of the
// two-wire controller. Assumes one 20 MHz clock and synchronous inputs.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
// How it works
// - Identity register holds a 4-bit revision in low bits, zeros above.
// - Soft reset keeps configuration fields and its own register bit.
// - While soft reset is held, no master or slave activity takes place.
// - While soft reset is held, both bus lines are left undriven.
// - Soft reset stays set until software writes it back to zero.
// - Entering soft reset aborts any transfer in progress.
// - Soft reset returns every status indication to its reset value.
// - Leaving soft reset never starts a boot loading sequence.
// - Leaving soft reset runs bus idle detection before any traffic.
// - Soft reset never recaptures straps; strapped fields keep values.
// - Byte order bit: zero sends or fills data most significant first.
// - Offset width: none, low byte, high then low; code three acts as none.
// - Transfers are addressed to the 7-bit target device address.
// - Chip reset returns every register to its reset value.
module imc_top (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [19:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [6:0]  strap_addr_in,
  input  wire logic        xfer_start_in,
  input  wire logic        xfer_write_in,
  input  wire logic [2:0]  xfer_size_in,
  input  wire logic [15:0] xfer_paddr_in,
  input  wire logic [31:0] xfer_tdata_in,
  output logic             xfer_busy_out,
  output logic             xfer_done_out,
  output logic             xfer_nack_out,
  output logic [31:0]      xfer_rdata_out,
  output logic             in_soft_reset_out,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_out,
  input  wire logic        serial_data_pin_in,
  output logic             serial_data_pin_out,
  output logic             serial_data_pin_oe_out
);
  logic              soft_block_reset_r;
  logic              byte_order_select_r;
  logic [1:0]        peripheral_offset_width_r;
  logic [6:0]        target_device_address_r;
  logic              strap_done_r;
  logic [31:0]       prdata_r;
  logic              bus_free_r;
  logic [7:0]        idle_cnt_r;
  imc_pkg::imc_seq_t seq_r;
  logic              pend_r;
  logic              cmd_valid_r;
  imc_pkg::imc_cmd_t cmd_r;
  imc_pkg::imc_cmd_t cmd_nxt;
  logic [8:0]        tx_r;
  logic [8:0]        tx_nxt;
  logic              wr_r;
  logic [2:0]        nbytes_r;
  logic [2:0]        cnt_r;
  logic [15:0]       off_r;
  logic [31:0]       tdata_r;
  logic [31:0]       rdata_r;
  logic              nack_r;
  logic              done_r;
  logic              eng_ready;
  logic              eng_done;
  logic [8:0]        eng_rx;
  logic              apb_wr;
  logic              apb_rd_setup;
  logic              mapped;
  logic              last_byte;
  logic              addr_nxt_is_data;

  // Byte lane used for data byte number c of n bytes, by byte order.
  function automatic logic [4:0] lane_lsb(input logic [2:0] n,
                                          input logic [2:0] c,
                                          input logic       lsb_first);
    logic [2:0] idx;
    idx = lsb_first ? c : 3'(n - c - 3'h1);
    return {idx[1:0], 3'h0};
  endfunction

  assign mapped       = (paddr_in == imc_pkg::OFF_ID) ||
                        (paddr_in == imc_pkg::OFF_RST) ||
                        (paddr_in == imc_pkg::OFF_CFG);
  assign apb_wr       = psel_in && penable_in && pwrite_in && mapped;
  assign apb_rd_setup = psel_in && !penable_in && !pwrite_in;
  assign pready_out   = 1'h1;
  assign pslverr_out  = psel_in && penable_in && !mapped;
  assign prdata_out   = prdata_r;
  assign in_soft_reset_out = soft_block_reset_r;
  assign xfer_busy_out  = (seq_r != imc_pkg::SQ_IDLE);
  assign xfer_done_out  = done_r;
  assign xfer_nack_out  = nack_r;
  assign xfer_rdata_out = rdata_r;
  assign last_byte      = (cnt_r + 3'h1 == nbytes_r);
  assign addr_nxt_is_data = wr_r && (nbytes_r != 3'h0);

  // Only an explicit write clears the bit, so reset persists.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      soft_block_reset_r <= 1'h0;
    end else if (apb_wr && paddr_in == imc_pkg::OFF_RST) begin
      soft_block_reset_r <= pwdata_in[imc_pkg::SRST_BIT];
    end
  end

  // Configuration sees only chip reset, straps and software, never soft reset.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      byte_order_select_r       <= imc_pkg::ORDER_RST;
      peripheral_offset_width_r <= imc_pkg::PAW_RST;
      target_device_address_r   <= imc_pkg::DEV_RST;
      strap_done_r              <= 1'h0;
    end else if (!strap_done_r) begin
      target_device_address_r <= strap_addr_in;
      strap_done_r            <= 1'h1;
    end else if (apb_wr && paddr_in == imc_pkg::OFF_CFG) begin
      byte_order_select_r       <= pwdata_in[imc_pkg::ORDER_BIT];
      peripheral_offset_width_r <=
        pwdata_in[imc_pkg::PAW_LSB +: 2];
      target_device_address_r   <= pwdata_in[imc_pkg::DEV_LSB +: 7];
    end
  end

  // Read data is captured in the setup phase so the access needs no wait.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata_r <= 32'h0;
    end else if (apb_rd_setup) begin
      prdata_r <= 32'h0;
      if (paddr_in == imc_pkg::OFF_ID) begin
        prdata_r[imc_pkg::REV_LSB +: 4] <= imc_pkg::REV_VALUE;
      end else if (paddr_in == imc_pkg::OFF_RST) begin
        prdata_r[imc_pkg::SRST_BIT] <= soft_block_reset_r;
      end else if (paddr_in == imc_pkg::OFF_CFG) begin
        prdata_r[imc_pkg::ORDER_BIT]    <= byte_order_select_r;
        prdata_r[imc_pkg::PAW_LSB +: 2] <= peripheral_offset_width_r;
        prdata_r[imc_pkg::DEV_LSB +: 7] <= target_device_address_r;
      end
    end
  end

  // The counter freezes once the bus has been seen free long enough.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      idle_cnt_r <= 8'h00;
      bus_free_r <= 1'h0;
    end else if (soft_block_reset_r) begin
      idle_cnt_r <= 8'h00;
      bus_free_r <= 1'h0;
    end else if (!bus_free_r) begin
      if (!(scl_in && serial_data_pin_in)) begin
        idle_cnt_r <= 8'h00;
      end else if (idle_cnt_r == 8'(imc_pkg::IDLE_CYC - 1)) begin
        bus_free_r <= 1'h1;
      end else begin
        idle_cnt_r <= idle_cnt_r + 8'h01;
      end
    end
  end

  always_comb begin
    cmd_nxt = imc_pkg::CMD_BYTE;
    tx_nxt  = 9'h1ff;
    case (seq_r)
      imc_pkg::SQ_START, imc_pkg::SQ_RSTART: cmd_nxt = imc_pkg::CMD_START;
      imc_pkg::SQ_STOP: cmd_nxt = imc_pkg::CMD_STOP;
      imc_pkg::SQ_DEVW: tx_nxt = {target_device_address_r, 2'h1};
      imc_pkg::SQ_DEVR: tx_nxt = {target_device_address_r, 2'h3};
      imc_pkg::SQ_OFFH: tx_nxt = {off_r[15:8], 1'h1};
      imc_pkg::SQ_OFFL: tx_nxt = {off_r[7:0], 1'h1};
      imc_pkg::SQ_DATA: begin
        if (wr_r) begin
          tx_nxt = {tdata_r[lane_lsb(nbytes_r, cnt_r,
                    byte_order_select_r) +: 8], 1'h1};
        end else begin
          tx_nxt = {8'hff, last_byte};
        end
      end
      default: tx_nxt = 9'h1ff;
    endcase
  end

  // Soft reset clears sequencer and status; exit goes to idle, not boot.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      seq_r       <= imc_pkg::SQ_IDLE;
      pend_r      <= 1'h0;
      cmd_valid_r <= 1'h0;
      cmd_r       <= imc_pkg::CMD_STOP;
      tx_r        <= 9'h1ff;
      wr_r        <= 1'h0;
      nbytes_r    <= 3'h0;
      cnt_r       <= 3'h0;
      off_r       <= 16'h0;
      tdata_r     <= 32'h0;
      rdata_r     <= 32'h0;
      nack_r      <= 1'h0;
      done_r      <= 1'h0;
    end else if (soft_block_reset_r) begin
      seq_r       <= imc_pkg::SQ_IDLE;
      pend_r      <= 1'h0;
      cmd_valid_r <= 1'h0;
      cnt_r       <= 3'h0;
      rdata_r     <= 32'h0;
      nack_r      <= 1'h0;
      done_r      <= 1'h0;
    end else begin
      done_r      <= 1'h0;
      cmd_valid_r <= 1'h0;
      if (seq_r == imc_pkg::SQ_IDLE) begin
        if (xfer_start_in && bus_free_r) begin
          seq_r    <= imc_pkg::SQ_START;
          wr_r     <= xfer_write_in;
          nbytes_r <= (xfer_size_in > imc_pkg::MAX_BYTES) ? 3'h0
                      : xfer_size_in;
          cnt_r    <= 3'h0;
          off_r    <= xfer_paddr_in;
          tdata_r  <= xfer_tdata_in;
          nack_r   <= 1'h0;
        end
      end else if (!pend_r && eng_ready) begin
        cmd_valid_r <= 1'h1;
        pend_r      <= 1'h1;
        cmd_r       <= cmd_nxt;
        tx_r        <= tx_nxt;
      end else if (eng_done) begin
        pend_r <= 1'h0;
        case (seq_r)
          imc_pkg::SQ_START: begin
            if (wr_r || peripheral_offset_width_r == imc_pkg::PAW_LOW ||
                peripheral_offset_width_r == imc_pkg::PAW_BOTH) begin
              seq_r <= imc_pkg::SQ_DEVW;
            end else begin
              seq_r <= imc_pkg::SQ_DEVR;
            end
          end
          imc_pkg::SQ_DEVW: begin
            if (eng_rx[0]) begin
              nack_r <= 1'h1;
              seq_r  <= imc_pkg::SQ_STOP;
            end else if (peripheral_offset_width_r == imc_pkg::PAW_BOTH) begin
              seq_r <= imc_pkg::SQ_OFFH;
            end else if (peripheral_offset_width_r == imc_pkg::PAW_LOW) begin
              seq_r <= imc_pkg::SQ_OFFL;
            end else if (addr_nxt_is_data) begin
              seq_r <= imc_pkg::SQ_DATA;
            end else if (wr_r) begin
              seq_r <= imc_pkg::SQ_STOP;
            end else begin
              seq_r <= imc_pkg::SQ_RSTART;
            end
          end
          imc_pkg::SQ_OFFH: begin
            nack_r <= eng_rx[0];
            seq_r  <= eng_rx[0] ? imc_pkg::SQ_STOP : imc_pkg::SQ_OFFL;
          end
          imc_pkg::SQ_OFFL: begin
            nack_r <= eng_rx[0];
            if (eng_rx[0] || (wr_r && !addr_nxt_is_data)) begin
              seq_r <= imc_pkg::SQ_STOP;
            end else begin
              seq_r <= wr_r ? imc_pkg::SQ_DATA : imc_pkg::SQ_RSTART;
            end
          end
          imc_pkg::SQ_RSTART: seq_r <= imc_pkg::SQ_DEVR;
          imc_pkg::SQ_DEVR: begin
            nack_r <= eng_rx[0];
            if (eng_rx[0] || nbytes_r == 3'h0) begin
              seq_r <= imc_pkg::SQ_STOP;
            end else begin
              seq_r <= imc_pkg::SQ_DATA;
            end
          end
          imc_pkg::SQ_DATA: begin
            if (!wr_r) begin
              rdata_r[lane_lsb(nbytes_r, cnt_r,
                      byte_order_select_r) +: 8] <= eng_rx[8:1];
            end
            cnt_r <= cnt_r + 3'h1;
            if (wr_r && eng_rx[0]) begin
              nack_r <= 1'h1;
              seq_r  <= imc_pkg::SQ_STOP;
            end else if (last_byte) begin
              seq_r <= imc_pkg::SQ_STOP;
            end
          end
          default: begin
            seq_r  <= imc_pkg::SQ_IDLE;
            done_r <= 1'h1;
          end
        endcase
      end
    end
  end

  imc_bit_engine u_engine (
    .clk_in       (clk_in),
    .rstn_in      (rstn_in),
    .hold_in      (soft_block_reset_r),
    .cmd_valid_in (cmd_valid_r),
    .cmd_in       (cmd_r),
    .tx_in        (tx_r),
    .ready_out    (eng_ready),
    .done_out     (eng_done),
    .rx_out       (eng_rx),
    .scl_in       (scl_in),
    .scl_out      (scl_out),
    .scl_oe_out   (scl_oe_out),
    .sda_in       (serial_data_pin_in),
    .sda_out      (serial_data_pin_out),
    .sda_oe_out   (serial_data_pin_oe_out)
  );

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_id_read: assert property (apb_rd_setup &&
    paddr_in == imc_pkg::OFF_ID
    |=> prdata_out == {28'h0, imc_pkg::REV_VALUE})
    else $error("identification read returned a wrong value");
  a_cfg_kept: assert property ($rose(soft_block_reset_r)
    |-> $stable(peripheral_offset_width_r) && $stable(byte_order_select_r))
    else $error("configuration changed on soft reset");
  a_lines_released: assert property (soft_block_reset_r[*2]
    |-> !scl_oe_out && !serial_data_pin_oe_out)
    else $error("bus line driven during soft reset");
  a_reset_sticks: assert property (soft_block_reset_r && !apb_wr
    |=> soft_block_reset_r)
    else $error("soft reset released without a write");
  a_abort_xfer: assert property (soft_block_reset_r
    |=> !xfer_busy_out && !xfer_done_out)
    else $error("transfer survived soft reset");
  a_status_clear: assert property (soft_block_reset_r
    |=> !xfer_nack_out && xfer_rdata_out == 32'h0)
    else $error("status not cleared by soft reset");
  a_idle_wait: assert property ($fell(soft_block_reset_r)
    |-> !bus_free_r ##1 !bus_free_r)
    else $error("idle detection skipped after soft reset");
  a_strap_kept: assert property ($fell(soft_block_reset_r)
    |-> $stable(target_device_address_r))
    else $error("strapped address changed on soft reset");
  a_dev_sent: assert property (cmd_valid_r && seq_r == imc_pkg::SQ_DEVW
    |-> tx_r[8:2] == target_device_address_r && !tx_r[1])
    else $error("wrong device address sent");
  a_off_low: assert property (seq_r == imc_pkg::SQ_DEVW && eng_done &&
    !eng_rx[0] && peripheral_offset_width_r == imc_pkg::PAW_LOW
    |=> seq_r == imc_pkg::SQ_OFFL)
    else $error("low offset byte not selected");
  a_first_msb: assert property (cmd_valid_r && wr_r &&
    seq_r == imc_pkg::SQ_DATA && cnt_r == 3'h0 && !byte_order_select_r &&
    nbytes_r == 3'h4 |-> tx_r[8:1] == tdata_r[31:24])
    else $error("first byte not most significant");

  c_soft_reset: cover property ($rose(soft_block_reset_r));
  c_write_done: cover property (xfer_done_out && wr_r && !xfer_nack_out);
  c_read_two_off: cover property (xfer_done_out && !wr_r &&
    peripheral_offset_width_r == imc_pkg::PAW_BOTH);
endmodule

// ---- tb/imc_slave_model.sv ----
// Two-wire slave at address 7'h50: acks writes, sends 8'ha0 + index.
// Assumes resolved pulled-up lines; releases the data line on a hang.
`timescale 1ns/1ps
module imc_slave_model (
  input  wire logic clk_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_oe_out
);
  logic [7:0] sh = 8'h00;
  logic [7:0] d;
  logic [7:0] got[$];
  logic       rd = 1'b0;
  int         bitn = 0;
  int         byten = 0;
  int         hi = 0;
  initial sda_oe_out = 1'b0;
  always @(negedge sda_in) if (scl_in) begin
    bitn = 0;
    byten = 0;
    rd = 1'b0;
  end
  always @(posedge scl_in) begin
    sh = {sh[6:0], sda_in};
    bitn++;
    if (bitn == 8) got.push_back(sh);
    if (bitn == 8 && byten == 0) rd = sh[0];
    if (bitn == 9) begin
      bitn = 0;
      byten++;
    end
  end
  // The master acks read data itself, so the model acks only what it takes.
  always @(negedge scl_in) begin
    d = 8'ha0 + 8'(byten);
    if (bitn == 8)
      sda_oe_out <= !(rd && byten > 0) && (byten > 0 || sh[7:1] == 7'h50);
    else sda_oe_out <= rd && byten > 0 && !d[7-bitn];
  end
  // A clock left high this long means the master has gone away.
  always @(posedge clk_in) begin
    hi = scl_in ? hi + 1 : 0;
    if (hi > 200) sda_oe_out <= 1'b0;
  end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench: APB register access, transfers and soft reset.
// Assumes imc_top alone with the slave model on pulled-up lines.
`timescale 1ns/1ps
module testbench;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [19:0] pa = 20'h00000;
  logic [31:0] pwd = 32'h0;
  logic        start = 1'b0;
  logic        xw = 1'b0;
  logic [2:0]  xs = 3'h0;
  logic [6:0]  strap = 7'h2b;
  logic [31:0] prd, rd, xrd;
  logic        prdy, perr, err, busy, done, nack, insr, c_oe, d_oe, s_oe;
  logic        sco, sdo;
  int          num_errors = 0;
  int          comparisons = 0;
  wire         scl = !c_oe;
  wire         sda = !(d_oe || s_oe);
  always #25 clk_in = !clk_in;
  imc_top DUT (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
    .strap_addr_in(strap), .xfer_start_in(start), .xfer_write_in(xw),
    .xfer_size_in(xs), .xfer_paddr_in(16'h1234),
    .xfer_tdata_in(32'h11223344), .xfer_busy_out(busy),
    .xfer_done_out(done), .xfer_nack_out(nack), .xfer_rdata_out(xrd),
    .in_soft_reset_out(insr), .scl_in(scl), .scl_out(sco), .scl_oe_out(c_oe),
    .serial_data_pin_in(sda), .serial_data_pin_out(sdo),
    .serial_data_pin_oe_out(d_oe));
  imc_slave_model slv (.clk_in(clk_in), .scl_in(scl), .sda_in(sda),
    .sda_oe_out(s_oe));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [19:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (prdy !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic go(input logic w, input logic [2:0] s);
    @(posedge clk_in);
    start <= 1'b1;
    xw <= w;
    xs <= s;
    @(posedge clk_in);
    start <= 1'b0;
  endtask
  task automatic xfer(input logic w, input logic [2:0] s);
    int n;
    slv.got.delete();
    go(w, s);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (done !== 1'b1 && n < 20000);
    chk({31'h0, done}, 32'h1);
  endtask
  task automatic bytes(input logic [31:0] e, input int n);
    for (int k = 0; k < n; k++) begin
      chk({24'h0, slv.got[k]}, {24'h0, e[31-8*k -: 8]});
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #4_000_000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (150) @(posedge clk_in);
    apb(1, imc_pkg::OFF_ID, 32'hffffffff);
    apb(0, imc_pkg::OFF_ID, 32'h0);
    chk(rd, {28'h0, imc_pkg::REV_VALUE});
    apb(0, imc_pkg::OFF_RST, 32'h0);
    chk(rd, 32'h0);
    apb(0, imc_pkg::OFF_CFG, 32'h0);
    chk(rd, 32'h0000002b);
    apb(0, 20'h1d10c, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk({30'h0, sco, sdo}, 32'h0);
    $display("test registers done");
    apb(1, imc_pkg::OFF_CFG, 32'h00810050);
    apb(0, imc_pkg::OFF_CFG, 32'h0);
    chk(rd, 32'h00810050);
    xfer(1, 3'h2);
    bytes(32'ha0344433, 4);
    $display("test write done");
    apb(1, imc_pkg::OFF_CFG, 32'h00020050);
    xfer(0, 3'h2);
    bytes(32'ha01234a1, 4);
    chk(xrd, 32'h0000a1a2);
    apb(1, imc_pkg::OFF_CFG, 32'h00830050);
    xfer(0, 3'h2);
    bytes(32'ha1a1a200, 3);
    chk(xrd, 32'h0000a2a1);
    chk({31'h0, nack}, 32'h0);
    apb(1, imc_pkg::OFF_CFG, 32'h00000051);
    xfer(0, 3'h1);
    chk({31'h0, nack}, 32'h1);
    $display("test read done");
    apb(1, imc_pkg::OFF_CFG, 32'h00030050);
    strap <= 7'h11;
    go(1, 3'h4);
    repeat (3000) @(posedge clk_in);
    apb(1, imc_pkg::OFF_RST, 32'h80000000);
    repeat (2) @(posedge clk_in);
    chk({27'h0, insr, busy, c_oe, d_oe, nack}, 32'h10);
    apb(0, imc_pkg::OFF_RST, 32'h0);
    chk(rd, 32'h80000000);
    apb(0, imc_pkg::OFF_CFG, 32'h0);
    chk(rd, 32'h00030050);
    go(0, 3'h1);
    repeat (400) @(posedge clk_in);
    chk({31'h0, busy}, 32'h0);
    apb(1, imc_pkg::OFF_RST, 32'h0);
    go(0, 3'h1);
    repeat (20) @(posedge clk_in);
    chk({30'h0, busy, insr}, 32'h0);
    repeat (150) @(posedge clk_in);
    xfer(0, 3'h1);
    chk(xrd, 32'h000000a1);
    $display("test soft reset done");
    complete_run();
  end
endmodule
